// [pic_top.sv]
// pic_top.sv: prioritised interrupt controller with call insertion
// assumes: sequencer marks each instruction's last cycle; register port strobes are single cycle
`timescale 1ns/1ps
`include "pic_map.svh"
module pic_top
   import pic_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire pic_cpu_s cpu,
   input wire logic [6:0] req_flags,
   input wire logic [1:0] ext_edge_mode,
   output pic_call_s call,
   output logic [3:0] flag_clr,
   output logic [3:0] in_progress,
   output logic irq
);
   // ****************************************************************
   // registers
   // ****************************************************************
   logic [7:0] irq_enable_reg;
   logic [7:0] irq_prio_low_reg;
   logic [7:0] irq_prio_high_reg;
   logic [6:0] stat;
   logic [6:0] irq_en;
   logic [7:0] next_irq_enable_reg;
   logic [7:0] next_irq_prio_low_reg;
   logic [7:0] next_irq_prio_high_reg;
   logic [6:0] next_stat;
   logic [6:0] next_irq_en;
   logic [7:0] next_rdata;
   logic next_irq;
   logic wr_ctl;
   logic [6:0] clr_bits;

   // ****************************************************************
   // polling and arbitration
   // ****************************************************************
   logic [6:0] flags_q;
   logic ctl_written;
   logic next_ctl_written;
   logic [6:0] enabled;
   logic [13:0] levels;
   logic win_valid;
   logic [2:0] win_idx;
   logic [1:0] win_level;
   logic [1:0] hp_level;
   logic hp_block;
   logic instr_block;
   logic poll;
   logic accept;
   logic call_active;
   pic_call_s next_call;
   logic [3:0] next_flag_clr;
   logic [3:0] next_in_progress;

   assign wr_ctl = wr && (addr == `PIC_ADDR_ENABLE || addr == `PIC_ADDR_PRIO_LO || addr == `PIC_ADDR_PRIO_HI);
   assign clr_bits = (wr && addr == `PIC_ADDR_CLR) ? wdata[6:0] : 7'h00;

   always_comb begin
      next_irq_enable_reg = irq_enable_reg;
      next_irq_prio_low_reg = irq_prio_low_reg;
      next_irq_prio_high_reg = irq_prio_high_reg;
      next_irq_en = irq_en;
      if (wr) begin
         case (addr)
            `PIC_ADDR_ENABLE: next_irq_enable_reg = wdata;
            `PIC_ADDR_PRIO_LO: next_irq_prio_low_reg = wdata & `PIC_PRIO_MASK; // RQ13
            `PIC_ADDR_PRIO_HI: next_irq_prio_high_reg = wdata & `PIC_PRIO_MASK; // RQ13
            `PIC_ADDR_IRQEN: next_irq_en = wdata[6:0];
            default: next_irq_en = irq_en;
         endcase
      end
      // a vector taken in the clearing cycle still lands
      next_stat = stat & ~clr_bits;
      if (accept) begin
         next_stat[win_idx] = 1'b1;
      end
      next_irq = |(next_stat & next_irq_en);
      next_rdata = 8'h00;
      if (rd) begin
         case (addr)
            `PIC_ADDR_ENABLE: next_rdata = irq_enable_reg;
            `PIC_ADDR_PRIO_LO: next_rdata = irq_prio_low_reg;
            `PIC_ADDR_PRIO_HI: next_rdata = irq_prio_high_reg;
            `PIC_ADDR_STAT: next_rdata = {1'b0, stat};
            `PIC_ADDR_IRQEN: next_rdata = {1'b0, irq_en};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq_enable_reg <= `PIC_RST_ENABLE;
         irq_prio_low_reg <= `PIC_RST_PRIO_LO;
         irq_prio_high_reg <= `PIC_RST_PRIO_HI;
         stat <= 7'h00;
         irq_en <= 7'h00;
         rdata <= 8'h00;
         irq <= 1'b0;
      end else begin
         irq_enable_reg <= next_irq_enable_reg;
         irq_prio_low_reg <= next_irq_prio_low_reg;
         irq_prio_high_reg <= next_irq_prio_high_reg;
         stat <= next_stat;
         irq_en <= next_irq_en;
         rdata <= next_rdata;
         irq <= next_irq;
      end
   end

   // per-source gating and levels
   always_comb begin
      enabled = irq_enable_reg[`PIC_BIT_GLOBAL] ? (irq_enable_reg[6:0] & flags_q) : 7'h00; // RQ11 RQ12 RQ2
      levels = 14'h0000;
      for (int i = 0; i < `PIC_NUM_SRC - 1; i++) begin
         levels[2*i +: 2] = {irq_prio_high_reg[i], irq_prio_low_reg[i]}; // RQ14
      end
      levels[2*`PIC_SRC_CMP +: 2] = `PIC_LVL_CMP; // RQ15
   end

   pic_arbiter u_arb (
      .pending(enabled),
      .levels(levels),
      .valid(win_valid),
      .idx(win_idx),
      .level(win_level)
   );

   pic_call_seq u_call (
      .clk(clk),
      .rstn(rstn),
      .start(accept),
      .active(call_active)
   );

   // highest level now in service
   always_comb begin
      hp_level = 2'h0;
      for (int l = 0; l < 4; l++) begin
         if (in_progress[l]) begin
            hp_level = 2'(l);
         end
      end
   end

   assign hp_block = (|in_progress) && (win_level <= hp_level); // RQ4 RQ16
   // the write may land in the last cycle itself, or earlier in the instruction
   assign instr_block = cpu.return_from_isr || ctl_written || wr_ctl; // RQ5 RQ9
   // the call itself is an instruction the sequencer does not mark
   // polling every last cycle keeps a lone request between the latency bounds
   assign poll = cpu.last_cycle && !call_active; // RQ1 RQ8 RQ10
   // nothing latched: a denied winner is simply dropped this poll
   assign accept = poll && win_valid && !hp_block && !instr_block; // RQ3 RQ6

   always_comb begin
      next_ctl_written = ctl_written;
      if (poll) begin
         next_ctl_written = 1'b0;
      end else if (wr_ctl) begin
         next_ctl_written = 1'b1;
      end
      next_call.active = accept || (call_active && !(u_call.cnt == 3'h0));
      next_call.vector = call.vector;
      if (accept) begin
         next_call.vector = `PIC_VEC_BASE + (16'(win_idx) << `PIC_VEC_STEP_SH); // RQ17
      end
      next_flag_clr = 4'h0;
      if (accept) begin
         case (win_idx)
            `PIC_SRC_EXT0: next_flag_clr[0] = ext_edge_mode[0]; // RQ18
            `PIC_SRC_TMR0: next_flag_clr[1] = 1'b1; // RQ18
            `PIC_SRC_EXT1: next_flag_clr[2] = ext_edge_mode[1]; // RQ18
            `PIC_SRC_TMR1: next_flag_clr[3] = 1'b1; // RQ18
            default: next_flag_clr = 4'h0;
         endcase
      end
      next_in_progress = in_progress;
      if (accept) begin
         next_in_progress[win_level] = 1'b1;
      end else if (poll && cpu.return_from_isr && (|in_progress)) begin
         next_in_progress[hp_level] = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         flags_q <= 7'h00;
         ctl_written <= 1'b0;
         call <= '{active: 1'b0, vector: `PIC_VEC_RESET};
         flag_clr <= 4'h0;
         in_progress <= 4'h0;
      end else begin
         flags_q <= req_flags; // RQ2
         ctl_written <= next_ctl_written;
         call <= next_call;
         flag_clr <= next_flag_clr;
         in_progress <= next_in_progress;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_poll_last;
      @(posedge clk) disable iff (!rstn)
      accept |-> cpu.last_cycle;
   endproperty
   a_poll_last: assert property (p_poll_last) else $error("vectored outside a last cycle"); // RQ1

   property p_sampled;
      @(posedge clk) disable iff (!rstn)
      accept |-> |($past(req_flags) & (7'h01 << win_idx));
   endproperty
   a_sampled: assert property (p_sampled) else $error("vectored without a flag one cycle earlier"); // RQ2

   property p_ret_block;
      @(posedge clk) disable iff (!rstn)
      (cpu.last_cycle && cpu.return_from_isr) |-> !accept;
   endproperty
   a_ret_block: assert property (p_ret_block) else $error("vectored after a return"); // RQ5

   property p_global;
      @(posedge clk) disable iff (!rstn)
      accept |-> irq_enable_reg[`PIC_BIT_GLOBAL] && irq_enable_reg[win_idx];
   endproperty
   a_global: assert property (p_global) else $error("vectored a masked source"); // RQ11

   property p_level_block;
      @(posedge clk) disable iff (!rstn)
      accept |-> (in_progress >> win_level) == 4'h0;
   endproperty
   a_level_block: assert property (p_level_block) else $error("preempted by equal or lower level"); // RQ4

   property p_vector;
      @(posedge clk) disable iff (!rstn)
      accept |=> call.active && call.vector == `PIC_VEC_BASE + (16'($past(win_idx)) << `PIC_VEC_STEP_SH);
   endproperty
   a_vector: assert property (p_vector) else $error("wrong vector"); // RQ17

   property p_timer_clear;
      @(posedge clk) disable iff (!rstn)
      (accept && win_idx == `PIC_SRC_TMR0) |=> flag_clr[1] ##1 !flag_clr[1];
   endproperty
   a_timer_clear: assert property (p_timer_clear) else $error("timer flag not cleared once"); // RQ18

   property p_call_out;
      @(posedge clk) disable iff (!rstn)
      accept |=> call.active [*4] ##1 !call.active;
   endproperty
   a_call_out: assert property (p_call_out) else $error("call output not four cycles"); // RQ7

   property p_cmp_low;
      @(posedge clk) disable iff (!rstn)
      (accept && win_idx == `PIC_SRC_CMP) |-> win_level == `PIC_LVL_CMP;
   endproperty
   a_cmp_low: assert property (p_cmp_low) else $error("comparator not at lowest level"); // RQ15

   property p_write_block;
      @(posedge clk) disable iff (!rstn)
      (poll && (wr_ctl || ctl_written)) |-> !accept;
   endproperty
   a_write_block: assert property (p_write_block) else $error("vectored right after a control write"); // RQ5

   property p_no_overlap;
      @(posedge clk) disable iff (!rstn)
      call.active |-> !accept;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("vectored during a running call"); // RQ7

   property p_ext1_clear;
      @(posedge clk) disable iff (!rstn)
      (accept && win_idx == `PIC_SRC_EXT1) |=> flag_clr[2] == $past(ext_edge_mode[1]);
   endproperty
   a_ext1_clear: assert property (p_ext1_clear) else $error("ext1 clear ignores trigger mode"); // RQ18

   property p_soft_clear;
      @(posedge clk) disable iff (!rstn)
      (accept && win_idx > `PIC_SRC_TMR1) |=> flag_clr == 4'h0;
   endproperty
   a_soft_clear: assert property (p_soft_clear) else $error("software flag cleared by hardware"); // RQ18

   property p_clr_pulse;
      @(posedge clk) disable iff (!rstn)
      (flag_clr != 4'h0) |-> $past(accept);
   endproperty
   a_clr_pulse: assert property (p_clr_pulse) else $error("flag clear without a vector"); // RQ18

   property p_level_set;
      @(posedge clk) disable iff (!rstn)
      accept |=> in_progress[$past(win_level)];
   endproperty
   a_level_set: assert property (p_level_set) else $error("level not marked in service"); // RQ4

   property p_ret_pop;
      @(posedge clk) disable iff (!rstn)
      (poll && cpu.return_from_isr && (|in_progress)) |=> in_progress < $past(in_progress);
   endproperty
   a_ret_pop: assert property (p_ret_pop) else $error("return left service levels unchanged"); // RQ4

   property p_prio_unused;
      @(posedge clk) disable iff (!rstn)
      (irq_prio_low_reg[7:6] == 2'h0) && (irq_prio_high_reg[7:6] == 2'h0);
   endproperty
   a_prio_unused: assert property (p_prio_unused) else $error("unused priority bits set"); // RQ13
endmodule : pic_top

// [pic_map.svh]
// pic_map.svh: register offsets, field positions, reset values and timing counts
// assumes: included by bare name from the controller's module files; the package does not include it
//
// Overview of operation
// [RQ1] Flags may set any cycle; polling happens only in an instruction's final cycle.
// [RQ2] Polling looks at flag values registered one cycle earlier.
// [RQ3] An enabled, unblocked winner gets a hardware long call as the next instruction.
// [RQ4] A request is blocked while an equal or higher level routine runs.
// [RQ5] Return or enable/priority write in progress: one more instruction before vectoring.
// [RQ6] Blocked requests are not remembered; every poll is evaluated afresh.
// [RQ7] The inserted call lasts four cycles; at least five cycles request to handler.
// [RQ8] An unfinished polling instruction adds at most 3 cycles.
// [RQ9] Blocking by return or register access adds at most 7 cycles.
// [RQ10] Single interrupt latency lies above 5 and below 13 cycles.
// [RQ11] Enable bit 7 is global: 0 masks all, 1 defers to per-source bits.
// [RQ12] Enable bits: comparator 6, gp 5, serial 4, t1 3, ext1 2, t0 1, ext0 0.
// [RQ13] Priority low/high bits: gp 5, serial 4, t1 3, ext1 2, t0 1, ext0 0.
// [RQ14] Source level is {high bit, low bit}, levels 0 to 3.
// [RQ15] The comparator always sits at the lowest level.
// [RQ16] Higher level wins, ties go to lower vector; only higher levels preempt.
// [RQ17] Vectors: reset 0000, ext0 0003, t0 000B, ext1 0013, t1 001B, serial 0023, gp 002B, cmp 0033.
// [RQ18] Vectoring clears timer flags, and external flags only in edge mode.
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH

`define PIC_ADDR_ENABLE 8'hA8
`define PIC_ADDR_PRIO_HI 8'hB7
`define PIC_ADDR_PRIO_LO 8'hB8
`define PIC_ADDR_STAT 8'hC0
`define PIC_ADDR_CLR 8'hC1
`define PIC_ADDR_IRQEN 8'hC2

`define PIC_RST_ENABLE 8'h00
`define PIC_RST_PRIO_LO 8'h00
`define PIC_RST_PRIO_HI 8'h00
`define PIC_PRIO_MASK 8'h3F

`define PIC_BIT_GLOBAL 7
`define PIC_NUM_SRC 7
`define PIC_SRC_EXT0 3'h0
`define PIC_SRC_TMR0 3'h1
`define PIC_SRC_EXT1 3'h2
`define PIC_SRC_TMR1 3'h3
`define PIC_SRC_CMP 3'h6

`define PIC_VEC_RESET 16'h0000
`define PIC_VEC_BASE 16'h0003
`define PIC_VEC_STEP_SH 3
`define PIC_CALL_CYCLES 3'h4
`define PIC_LVL_CMP 2'h0

`endif

// [pic_pkg.sv]
// pic_pkg.sv: types shared by the interrupt controller modules
// assumes: pic_map.svh supplies all numeric constants
package pic_pkg;

   // sequencer status for the instruction now executing
   typedef struct packed {
      logic last_cycle;
      logic return_from_isr;
   } pic_cpu_s;

   // inserted long call toward the sequencer
   typedef struct packed {
      logic active;
      logic [15:0] vector;
   } pic_call_s;

   typedef enum logic [0:0] {
      PIC_CALL_IDLE = 1'b0,
      PIC_CALL_RUN = 1'b1
   } pic_call_state_e;

endpackage : pic_pkg

// [pic_arbiter.sv]
// pic_arbiter.sv: picks the highest level request, lowest vector among ties
// assumes: pending and levels are stable within the polling cycle
`timescale 1ns/1ps
`include "pic_map.svh"
module pic_arbiter
   import pic_pkg::*;
(
   input wire logic [6:0] pending,
   input wire logic [13:0] levels,
   output logic valid,
   output logic [2:0] idx,
   output logic [1:0] level
);
   always_comb begin
      valid = 1'b0;
      idx = 3'h0;
      level = 2'h0;
      // walk down so that on a tie the lower vector overwrites
      for (int i = `PIC_NUM_SRC - 1; i >= 0; i--) begin
         if (pending[i] && (!valid || levels[2*i +: 2] >= level)) begin // RQ16
            valid = 1'b1;
            idx = 3'(i);
            level = levels[2*i +: 2];
         end
      end
   end
endmodule : pic_arbiter

// [pic_call_seq.sv]
// pic_call_seq.sv: holds the inserted long call for its fixed number of cycles
// assumes: start only arrives while idle
`timescale 1ns/1ps
`include "pic_map.svh"
module pic_call_seq
   import pic_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   output logic active
);
   pic_call_state_e state;
   pic_call_state_e next_state;
   logic [2:0] cnt;
   logic [2:0] next_cnt;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         PIC_CALL_IDLE: begin
            if (start) begin
               next_state = PIC_CALL_RUN;
               next_cnt = `PIC_CALL_CYCLES - 3'h1;
            end
         end
         PIC_CALL_RUN: begin
            if (cnt == 3'h0) begin // RQ7
               next_state = PIC_CALL_IDLE;
            end else begin
               next_cnt = cnt - 3'h1;
            end
         end
         default: next_state = PIC_CALL_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state <= PIC_CALL_IDLE;
         cnt <= 3'h0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   assign active = (state == PIC_CALL_RUN);

   property p_call_len;
      @(posedge clk) disable iff (!rstn)
      (state == PIC_CALL_IDLE && start) |=> active [*4] ##1 !active;
   endproperty
   a_call_len: assert property (p_call_len) else $error("call not exactly four cycles"); // RQ7
endmodule : pic_call_seq

// [pic_seq_model.sv]
// pic_seq_model.sv: behavioural instruction sequencer beside the controller
// assumes: the bench sets the instruction length (1 to 4) and asks for returns
`timescale 1ns/1ps
module pic_seq_model
   import pic_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] ilen,
   input wire logic ret_req,
   input wire pic_call_s call,
   output pic_cpu_s cpu
);
   logic [2:0] cnt;
   logic ret_pend;
   logic fin;
   // no final cycle while the inserted call runs; >= keeps a shortened length from wrapping
   assign fin = (cnt >= ilen - 3'h1) && !call.active;
   assign cpu.last_cycle = fin;
   assign cpu.return_from_isr = fin && ret_pend;
   always_ff @(posedge clk) begin
      if (!rstn || call.active || fin) begin
         cnt <= 3'h0;
      end else begin
         cnt <= cnt + 3'h1;
      end
   end
   // a requested return marks the next instruction to finish
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ret_pend <= 1'b0;
      end else if (ret_req) begin
         ret_pend <= 1'b1;
      end else if (fin) begin
         ret_pend <= 1'b0;
      end
   end
endmodule : pic_seq_model

// [pic_tb.sv]
// pic_tb.sv: bench for the interrupt controller
// assumes: pic_seq_model drives the sequencer side; flag sources are driven here
`timescale 1ns/1ps
`include "pic_map.svh"
module prioritized_interrupt_controller_test
   import pic_pkg::*;
();
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   pic_cpu_s cpu;
   logic [6:0] req_flags = 7'h00;
   logic [1:0] ext_edge_mode = 2'h1;
   pic_call_s call;
   logic [3:0] flag_clr;
   logic [3:0] in_progress;
   logic irq;
   logic [2:0] ilen = 3'h2;
   logic ret_req = 1'b0;
   int errors = 0;
   int checks = 0;
   int polls = 0;
   int wpoll;
   int rpoll;
   int cpoll;
   int resp;
   logic ok;
   logic [15:0] vec;
   logic [3:0] clr;
   logic [7:0] d;
   logic [15:0] vtab [7] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B, 16'h0033};
   // ext1 runs in level mode, so hardware leaves its flag alone
   logic [3:0] ctab [7] = '{4'h1, 4'h2, 4'h0, 4'h8, 4'h0, 4'h0, 4'h0};

   pic_top u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .cpu(cpu), .req_flags(req_flags), .ext_edge_mode(ext_edge_mode), .call(call), .flag_clr(flag_clr),
      .in_progress(in_progress), .irq(irq));
   pic_seq_model u_seq (.clk(clk), .rstn(rstn), .ilen(ilen), .ret_req(ret_req), .call(call), .cpu(cpu));

   initial begin
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (cpu.last_cycle === 1'b1) begin
         polls <= polls + 1;
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      #1;
      wpoll = polls;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd_reg
   task automatic flags(input logic [6:0] f);
      @(posedge clk);
      req_flags <= f;
      #1;
   endtask : flags
   // bounded wait for a call; resp counts cycles to the first handler cycle
   task automatic wait_call;
      int n;
      n = 0;
      while (call.active !== 1'b1 && n < 30) begin
         @(posedge clk);
         #1;
         n++;
      end
      ok = call.active;
      vec = call.vector;
      clr = flag_clr;
      cpoll = polls;
      resp = n;
      n = 0;
      while (call.active === 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      resp = resp + n;
      if (ok === 1'b1) check("call length", 16'h0004, 16'(n));
   endtask : wait_call
   task automatic end_isr;
      int n;
      n = 0;
      @(posedge clk);
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
      #1;
      while (cpu.return_from_isr !== 1'b1 && n < 10) begin
         @(posedge clk);
         #1;
         n++;
      end
      rpoll = polls;
      @(posedge clk);
      #1;
   endtask : end_isr
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(`PIC_ADDR_ENABLE, d);
      check("enable reset", `PIC_RST_ENABLE, d);
      rd_reg(`PIC_ADDR_PRIO_HI, d);
      check("prio high reset", `PIC_RST_PRIO_HI, d);
      rd_reg(8'h55, d);
      check("unmapped", 16'h0000, d);
      wr_reg(`PIC_ADDR_PRIO_LO, 8'hFF);
      rd_reg(`PIC_ADDR_PRIO_LO, d);
      check("prio low bits", 16'h003F, d);
      wr_reg(`PIC_ADDR_PRIO_HI, 8'hFF);
      rd_reg(`PIC_ADDR_PRIO_HI, d);
      check("prio high bits", 16'h003F, d);
      $display("test registers done");
      // per-source bits alone, then the global bit alone
      wr_reg(`PIC_ADDR_ENABLE, 8'h7F);
      flags(7'h7F);
      wait_call();
      check("global off", 16'h0000, ok);
      wr_reg(`PIC_ADDR_ENABLE, 8'h80);
      wait_call();
      check("sources off", 16'h0000, ok);
      flags(7'h00);
      $display("test masking done");
      wr_reg(`PIC_ADDR_ENABLE, 8'hFF);
      wr_reg(`PIC_ADDR_IRQEN, 8'h7F);
      for (int i = 0; i < 7; i++) begin
         ilen <= 3'(i % 4 + 1);
         flags(7'h01 << i);
         wait_call();
         check("vector", vtab[i], vec);
         check("flag clear", ctab[i], clr);
         check("level", (i == 6) ? 4'h1 : 4'h8, in_progress);
         check("response", 16'h0001, 16'((resp > 5) && (resp < 13)));
         rd_reg(`PIC_ADDR_STAT, d);
         check("status", 8'h01 << i, d);
         check("irq", 16'h0001, irq);
         flags(7'h00);
         end_isr();
         wr_reg(`PIC_ADDR_CLR, 8'h7F);
      end
      check("irq cleared", 16'h0000, irq);
      // ext1 in edge mode, ext0 in level mode
      ext_edge_mode <= 2'h2;
      flags(7'h04);
      wait_call();
      check("ext1 edge clear", 16'h0004, clr);
      flags(7'h00);
      end_isr();
      flags(7'h01);
      wait_call();
      check("ext0 level clear", 16'h0000, clr);
      flags(7'h00);
      end_isr();
      wr_reg(`PIC_ADDR_CLR, 8'h7F);
      $display("test vectors done");
      // serial level 1, timer1 level 2, ext0 level 0; status events hidden from irq
      wr_reg(`PIC_ADDR_IRQEN, 8'h00);
      wr_reg(`PIC_ADDR_PRIO_LO, 8'h10);
      wr_reg(`PIC_ADDR_PRIO_HI, 8'h08);
      ilen <= 3'h3;
      flags(7'h11);
      wait_call();
      check("level beats vector", 16'h0023, vec);
      check("serial level", 16'h0002, in_progress);
      flags(7'h01);
      wait_call();
      check("lower level blocked", 16'h0000, ok);
      rd_reg(`PIC_ADDR_STAT, d);
      check("status masked", 16'h0010, d);
      check("irq masked", 16'h0000, irq);
      flags(7'h08);
      wait_call();
      check("preempt", 16'h001B, vec);
      check("nested", 16'h0006, in_progress);
      flags(7'h00);
      end_isr();
      check("pop top", 16'h0002, in_progress);
      end_isr();
      wait_call();
      check("not remembered", 16'h0000, ok);
      $display("test priority done");
      ilen <= 3'h4;
      wr_reg(`PIC_ADDR_ENABLE, 8'h7F);
      flags(7'h01);
      wr_reg(`PIC_ADDR_ENABLE, 8'hFF);
      wait_call();
      check("after enable write", 16'h0001, ok);
      check("write block", 16'h0001, 16'(cpoll - wpoll >= 2));
      flags(7'h40);
      wait_call();
      check("equal level blocked", 16'h0000, ok);
      end_isr();
      wait_call();
      check("comparator vector", 16'h0033, vec);
      check("return block", 16'h0001, 16'(cpoll - rpoll >= 2));
      flags(7'h00);
      end_isr();
      $display("test blocking done");
      report_and_stop();
   end
   initial begin
      #200000;
      errors++;
      report_and_stop();
   end
endmodule : prioritized_interrupt_controller_test
